// ### hw/rbs_hyst.sv
`timescale 1ns/1ns
module rbs_hyst #(
    parameter int unsigned LEN = 4
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // synchronised raw level and debounced level
    input  wire logic level_in,
    output logic      level_out
);
    logic [$clog2(LEN+1)-1:0] cnt_q;

    // level changes only after LEN agreeing samples, so a noisy threshold
    // crossing yields one clean edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_q     <= '0;
            level_out <= 1'b0;
        end else if (level_in == level_out) begin
            cnt_q <= '0;
        end else if (cnt_q == ($clog2(LEN+1))'(LEN - 1)) begin
            cnt_q     <= '0;
            level_out <= level_in;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// ### hw/rbs_pkg.sv
package rbs_pkg;
    // system clock
    localparam int unsigned CLK_HZ          = 50_000_000;
    // wake-up timer fixed count of oscillator-qualified clocks
    localparam int unsigned WAKE_CYCLES     = 1024;
    localparam int unsigned WAKE_W          = 11;
    // flash start-up time
    localparam int unsigned FLASH_INIT_US   = 100;
    localparam int unsigned FLASH_CYCLES    = (FLASH_INIT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned FLASH_W         = 13;
    // oscillator nominal rate, used for the oscillator-rate tick divider
    localparam int unsigned OSC_HZ          = 4_000_000;
    localparam int unsigned OSC_DIV         = CLK_HZ / OSC_HZ;
    // input filter length for brownout indications
    localparam int unsigned FILT_LEN        = 4;
    // reset vector address and map selections
    localparam logic [31:0] RESET_VECTOR    = 32'h0000_0000;
    localparam logic        MAP_BOOT        = 1'b0;
    localparam logic        MAP_SRAM        = 1'b1;
    localparam logic        MAP_RESET       = MAP_BOOT;
    // external interrupt lines
    localparam int unsigned N_EINT          = 4;

    typedef enum logic [2:0] {
        RBS_OFF,
        RBS_HOLD,
        RBS_WAKE,
        RBS_FLASH,
        RBS_RUN,
        RBS_PDOWN,
        RBS_DPD
    } rbs_state_t;
endpackage

// ### hw/rbs_reset_brownout_sequencer.sv
// Functional notes
// - chip reset merges the pin, watchdog, power-on and second-stage brownout requests.
// - any reset starts the wake-up timer and holds reset until pin release, oscillator, count and flash init.
// - on release the core fetches from address zero with the vector from the source that map_sel selects.
// - all registers except the battery RAM hold reset values before internal reset is released.
// - supply below the first brownout threshold raises an interrupt toward the vectored_irq_ctrl.
// - the first-stage request is gated by its enable while its level stays readable as status.
// - supply below the second brownout threshold asserts chip reset to protect flash.
// - the brownout detector holds reset down toward the lower limit, then power-on takes over.
// - both brownout indications have hysteresis so the first stage gives one clean event.
// - main power returning after deep power-down gives a full start-up sequence.
// - battery RAM keeps its contents while the battery supply stays on.
// - the battery-domain clock alarm can drive an output to restore chip power.
// - each external interrupt can optionally wake the core from power-down.
// - a map control picks boot ROM or SRAM as the vector source at address zero.
// - deep power-down exits only on clock alarm, external reset or power-on, like a full reset.
// - after any reset or wake the clock source is the internal_rc_osc.
`timescale 1ns/1ns
module rbs_reset_brownout_sequencer
    import rbs_pkg::*;
#(
    parameter int unsigned WAKE_COUNT  = rbs_pkg::WAKE_CYCLES,
    parameter int unsigned FLASH_COUNT = rbs_pkg::FLASH_CYCLES,
    parameter int unsigned NEINT       = rbs_pkg::N_EINT,
    parameter int unsigned BRAM_DEPTH  = 512
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // reset sources, asynchronous
    input  wire logic                  ext_reset_n,
    input  wire logic                  wdt_expire,
    input  wire logic                  por_detect,
    // brownout_detector comparator outputs, high while below threshold
    input  wire logic                  bod_stage1_low,
    input  wire logic                  bod_stage2_low,
    input  wire logic                  below_1v,
    // oscillator and flash
    input  wire logic                  internal_rc_osc_ok,
    input  wire logic                  flash_init_done,
    // core power requests and configuration
    input  wire logic                  pdown_req,
    input  wire logic                  dpd_req,
    input  wire logic                  bod_irq_enable,
    input  wire logic                  map_sel,
    input  wire logic [NEINT-1:0]      eint_in,
    input  wire logic [NEINT-1:0]      eint_wake_en,
    // battery domain
    input  wire logic                  vbat_ok,
    input  wire logic                  rtc_alarm,
    input  wire logic                  bram_we,
    input  wire logic [8:0]            bram_addr,
    input  wire logic [31:0]           bram_wdata,
    // outputs
    output logic                       chip_reset_n,
    output logic                       core_reset_n,
    output logic                       flash_init_start,
    output logic [31:0]                fetch_addr,
    output logic                       vec_from_sram,
    output logic                       clk_src_irc,
    output logic                       bod_irq,
    output logic                       bod_status,
    output logic                       core_wake,
    output logic                       alarm_out,
    output logic [31:0]                bram_rdata,
    output logic [2:0]                 reset_cause
);
    logic              ext_rst_s;
    logic              wdt_s;
    logic              por_s;
    logic              b1_s;
    logic              b2_s;
    logic              lo_s;
    logic              osc_s;
    logic              fl_s;
    logic              alarm_s;
    logic              vbat_s;
    logic [NEINT-1:0]  eint_s;
    logic              b1_h;
    logic              b2_h;
    logic              any_rst;
    logic [1:0]        rsync_q;
    rbs_state_t        state_q;
    logic [WAKE_W-1:0] wake_q;
    logic [FLASH_W-1:0] fl_q;
    logic [7:0]        div_q;
    logic              osc_tick;
    logic              core_live;
    logic [31:0]       bram_q [BRAM_DEPTH];

    rbs_sync #(.W(10 + NEINT)) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({~ext_reset_n, wdt_expire, por_detect, bod_stage1_low, bod_stage2_low,
                    below_1v, internal_rc_osc_ok, flash_init_done, rtc_alarm, vbat_ok,
                    eint_in}),
        .sync_out ({ext_rst_s, wdt_s, por_s, b1_s, b2_s, lo_s, osc_s, fl_s, alarm_s,
                    vbat_s, eint_s})
    );

    rbs_hyst #(.LEN(FILT_LEN)) u_hyst1 (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .level_in  (b1_s),
        .level_out (b1_h)
    );

    rbs_hyst #(.LEN(FILT_LEN)) u_hyst2 (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .level_in  (b2_s),
        .level_out (b2_h)
    );

    assign any_rst = ext_rst_s | wdt_s | por_s | b2_h | lo_s;

    // oscillator-rate enable so the fixed count is in oscillator clocks
    // the divide rounds down, so the counted wait runs slightly short of nominal
    always_ff @(posedge sys_clk) begin
        if (!rst_n || div_q == 8'(OSC_DIV - 1)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign osc_tick = (div_q == 8'(OSC_DIV - 1));

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= RBS_HOLD;
            wake_q  <= '0;
            fl_q    <= '0;
        end else if (any_rst && state_q != RBS_DPD) begin
            state_q <= RBS_HOLD;
            wake_q  <= '0;
            fl_q    <= '0;
        end else begin
            unique case (state_q)
                RBS_OFF: begin
                    state_q <= RBS_HOLD;
                end
                RBS_HOLD: begin
                    // counters restart each time the oscillator drops out during the wake-up wait
                    wake_q <= '0;
                    fl_q   <= '0;
                    if (osc_s) begin
                        state_q <= RBS_WAKE;
                    end
                end
                RBS_WAKE: begin
                    // the last of the full count of ticks ends the wait,
                    // not the tick before it
                    if (!osc_s) begin
                        state_q <= RBS_HOLD;
                    end else if (osc_tick) begin
                        if (wake_q == WAKE_W'(WAKE_COUNT - 1)) begin
                            state_q <= RBS_FLASH;
                        end else begin
                            wake_q <= wake_q + 1'b1;
                        end
                    end
                end
                RBS_FLASH: begin
                    // fixed time first, then the flash controller's own done level
                    if (fl_q != FLASH_W'(FLASH_COUNT - 1)) begin
                        fl_q <= fl_q + 1'b1;
                    end else if (fl_s) begin
                        state_q <= RBS_RUN;
                    end
                end
                RBS_RUN: begin
                    if (dpd_req) begin
                        state_q <= RBS_DPD;
                    end else if (pdown_req) begin
                        state_q <= RBS_PDOWN;
                    end
                end
                RBS_PDOWN: begin
                    if (|(eint_s & eint_wake_en)) begin
                        state_q <= RBS_RUN;
                    end
                end
                RBS_DPD: begin
                    // core logic is unpowered here, so watchdog and brownout are ignored
                    if (alarm_s || ext_rst_s || por_s) begin
                        state_q <= RBS_HOLD;
                    end
                end
                default: state_q <= RBS_HOLD;
            endcase
        end
    end

    // core stays out of reset through power-down, it only loses its clock
    assign core_live = (state_q == RBS_RUN) || (state_q == RBS_PDOWN);

    always_ff @(posedge sys_clk or posedge any_rst) begin
        if (any_rst) begin
            rsync_q <= 2'b00;
        end else if (!rst_n) begin
            rsync_q <= 2'b00;
        end else begin
            rsync_q <= {rsync_q[0], core_live};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            chip_reset_n     <= 1'b0;
            core_reset_n     <= 1'b0;
            flash_init_start <= 1'b0;
        end else begin
            chip_reset_n     <= ~any_rst & (state_q != RBS_DPD);
            core_reset_n     <= rsync_q[1];
            flash_init_start <= (state_q == RBS_FLASH);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !rsync_q[1]) begin
            fetch_addr    <= RESET_VECTOR;
            vec_from_sram <= MAP_RESET;
            clk_src_irc   <= 1'b1;
        end else begin
            fetch_addr    <= RESET_VECTOR;
            vec_from_sram <= (map_sel == MAP_SRAM);
            clk_src_irc   <= clk_src_irc;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bod_irq    <= 1'b0;
            bod_status <= 1'b0;
        end else begin
            bod_irq    <= b1_h & bod_irq_enable;
            bod_status <= b1_h;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            core_wake <= 1'b0;
        end else begin
            core_wake <= (state_q == RBS_PDOWN) && (|(eint_s & eint_wake_en));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            alarm_out <= 1'b0;
        end else begin
            alarm_out <= alarm_s & vbat_s;
        end
    end

    // battery RAM not cleared by reset
    // no reset branch: the contents must outlive every chip reset
    always_ff @(posedge sys_clk) begin
        if (vbat_s && bram_we && state_q == RBS_RUN) begin
            bram_q[bram_addr] <= bram_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bram_rdata <= 32'h0000_0000;
        end else begin
            bram_rdata <= bram_q[bram_addr];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reset_cause <= 3'h0;
        end else if (any_rst) begin
            // first source in priority order wins when several are seen together
            reset_cause <= ext_rst_s ? 3'h1 : wdt_s ? 3'h2 : por_s ? 3'h3 : 3'h4;
        end
    end
endmodule

// ### hw/rbs_sync.sv
`timescale 1ns/1ns
module rbs_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // async input and synchronised output
    input  wire logic [W-1:0] async_in,
    output logic [W-1:0]      sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ### verification/rbs_partner.sv
`timescale 1ns/1ns
module rbs_partner (
    // clock and supply
    input  wire logic sys_clk,
    input  wire logic pwr_on,
    // flash start request
    input  wire logic flash_init_start,
    // oscillator and flash answers
    output logic      internal_rc_osc_ok,
    output logic      flash_init_done
);
    logic [4:0] osc_q = 5'h00;
    logic [6:0] fl_q  = 7'h00;
    always_ff @(posedge sys_clk) begin
        osc_q <= {osc_q[3:0], pwr_on};
    end
    assign internal_rc_osc_ok = osc_q[4];
    // flash init latency; done drops with start, no sticky kindness
    always_ff @(posedge sys_clk) begin
        fl_q <= {fl_q[5:0], flash_init_start};
    end
    assign flash_init_done = fl_q[6];
endmodule

// ### verification/rbs_sequencer_asserts.sv
`timescale 1ns/1ns
module rbs_sequencer_asserts
    import rbs_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // sources and qualifiers
    input wire logic        ext_reset_n,
    input wire logic        wdt_expire,
    input wire logic        por_detect,
    input wire logic        bod_stage2_low,
    input wire logic        below_1v,
    input wire logic        internal_rc_osc_ok,
    input wire logic        flash_init_done,
    input wire logic        bod_irq_enable,
    // sequencer outputs
    input wire logic        chip_reset_n,
    input wire logic        core_reset_n,
    input wire logic [31:0] fetch_addr,
    input wire logic        bod_irq,
    input wire logic        bod_status
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_pin_to_chip: assert property ($fell(ext_reset_n) |-> ##[1:4] !chip_reset_n)
        else $error("pin did not reset chip");
    a_wdt_to_chip: assert property ($rose(wdt_expire) |-> ##[1:4] !chip_reset_n)
        else $error("watchdog did not reset chip");
    a_por_to_chip: assert property ($rose(por_detect) |-> ##[1:4] !chip_reset_n)
        else $error("power-on did not reset chip");
    a_bod_to_chip: assert property ($rose(bod_stage2_low) |-> ##[1:8] !chip_reset_n)
        else $error("brownout did not reset chip");
    a_low_to_chip: assert property ($rose(below_1v) |-> ##[1:4] !chip_reset_n)
        else $error("low supply did not reset chip");
    a_release_qual: assert property ($rose(core_reset_n) |->
        ext_reset_n && internal_rc_osc_ok && flash_init_done)
        else $error("core released too early");
    a_fetch_zero: assert property (core_reset_n |-> fetch_addr == RESET_VECTOR)
        else $error("fetch address not zero");
    a_irq_raised: assert property (bod_status && bod_irq_enable |-> ##[0:2] bod_irq)
        else $error("brownout irq missing");
    a_irq_gated: assert property (!bod_irq_enable [*3] |-> !bod_irq)
        else $error("masked irq raised");

    c_release: cover property ($rose(core_reset_n));
    c_chip_reset: cover property ($fell(chip_reset_n));
    c_irq: cover property ($rose(bod_irq));
endmodule

bind rbs_reset_brownout_sequencer rbs_sequencer_asserts u_chk (.sys_clk, .rst_n,
    .ext_reset_n, .wdt_expire, .por_detect, .bod_stage2_low, .below_1v, .internal_rc_osc_ok,
    .flash_init_done, .bod_irq_enable, .chip_reset_n, .core_reset_n, .fetch_addr,
    .bod_irq, .bod_status);

// ### verification/tb.sv
`timescale 1ns/1ns
module tb;
    import rbs_pkg::*;
    logic        sys_clk = 1'b0, rst_n = 1'b0, ext_reset_n = 1'b1, wdt_expire = 1'b0;
    logic        por_detect = 1'b1, bod_stage1_low = 1'b0, bod_stage2_low = 1'b0;
    logic        pdown_req = 1'b0, dpd_req = 1'b0, bod_irq_enable = 1'b0, map_sel = 1'b0;
    logic        rtc_alarm = 1'b0, bram_we = 1'b0, pwr_on = 1'b1, below_1v = 1'b0;
    logic        vbat_ok = 1'b1;
    logic [3:0]  eint_in = 4'h0, eint_wake_en = 4'h0;
    logic [31:0] fetch_addr, bram_rdata;
    logic        internal_rc_osc_ok, flash_init_done, chip_reset_n, core_reset_n;
    logic        flash_init_start, vec_from_sram, clk_src_irc, bod_irq, bod_status;
    logic        core_wake, alarm_out;
    logic [2:0]  reset_cause;
    int          num_errors = 0, checks = 0;

    rbs_reset_brownout_sequencer #(.WAKE_COUNT(4), .FLASH_COUNT(4)) uut (.sys_clk, .rst_n,
        .ext_reset_n, .wdt_expire, .por_detect, .bod_stage1_low, .bod_stage2_low,
        .below_1v, .internal_rc_osc_ok, .flash_init_done, .pdown_req, .dpd_req,
        .bod_irq_enable, .map_sel, .eint_in, .eint_wake_en, .vbat_ok, .rtc_alarm,
        .bram_we, .bram_addr(9'h1a5), .bram_wdata(32'h5a5a_c3c3), .chip_reset_n,
        .core_reset_n, .flash_init_start, .fetch_addr, .vec_from_sram, .clk_src_irc,
        .bod_irq, .bod_status, .core_wake, .alarm_out, .bram_rdata, .reset_cause);
    rbs_partner u_far (.sys_clk, .pwr_on, .flash_init_start, .internal_rc_osc_ok,
        .flash_init_done);

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // bounded wait, the sequencer length is set by small parameters
    task automatic wait_core;
        for (int i = 0; i < 400 && core_reset_n !== 1'b1; i++) tick(1);
        chk(core_reset_n, 1, "core held in reset");
    endtask
    task automatic t_power_up;
        por_detect = 1'b0;
        wait_core();
        chk(clk_src_irc, 1, "clock source");
        chk(vec_from_sram, MAP_RESET, "vector map");
        chk(fetch_addr, RESET_VECTOR, "fetch address");
        bram_we = 1'b1;
        tick(1);
        bram_we = 1'b0;
        $display("test power_up done");
    endtask
    task automatic t_sources;
        for (int k = 0; k < 5; k++) begin
            ext_reset_n = (k != 0);
            wdt_expire = (k == 1);
            por_detect = (k == 2);
            bod_stage2_low = (k == 3);
            below_1v = (k == 4);
            tick(8);
            chk(chip_reset_n, 0, "chip not reset");
            chk(core_reset_n, 0, "core not reset");
            chk(flash_init_start, 0, "flash started in reset");
            ext_reset_n = 1'b1;
            wdt_expire = 1'b0;
            por_detect = 1'b0;
            bod_stage2_low = 1'b0;
            below_1v = 1'b0;
            wait_core();
            chk(reset_cause, (k == 4) ? 4 : k + 1, "reset cause");
            chk(bram_rdata, 32'h5a5a_c3c3, "battery ram");
        end
        $display("test sources done");
    endtask
    task automatic t_brownout;
        bod_stage1_low = 1'b1;
        tick(1);
        bod_stage1_low = 1'b0;
        tick(10);
        chk(bod_status, 0, "glitch passed");
        bod_stage1_low = 1'b1;
        tick(10);
        chk(bod_status, 1, "status low");
        chk(bod_irq, 0, "masked irq");
        bod_irq_enable = 1'b1;
        tick(3);
        chk(bod_irq, 1, "irq missing");
        bod_stage1_low = 1'b0;
        bod_irq_enable = 1'b0;
        tick(10);
        chk(bod_status, 0, "status stuck");
        map_sel = MAP_SRAM;
        tick(4);
        chk(vec_from_sram, 1, "vector map");
        vbat_ok = 1'b0;
        rtc_alarm = 1'b1;
        tick(6);
        chk(alarm_out, 0, "alarm without battery");
        rtc_alarm = 1'b0;
        vbat_ok = 1'b1;
        tick(4);
        $display("test brownout_map done");
    endtask
    task automatic t_power_down;
        eint_wake_en = 4'h1;
        pdown_req = 1'b1;
        tick(1);
        pdown_req = 1'b0;
        eint_in = 4'h2;
        tick(8);
        chk(core_wake, 0, "disabled line woke");
        eint_in = 4'h1;
        for (int i = 0; i < 20 && core_wake !== 1'b1; i++) tick(1);
        chk(core_wake, 1, "no wake");
        eint_in = 4'h0;
        wait_core();
        dpd_req = 1'b1;
        tick(1);
        dpd_req = 1'b0;
        tick(8);
        chk(core_reset_n, 0, "deep power-down");
        rtc_alarm = 1'b1;
        tick(6);
        chk(alarm_out, 1, "alarm output");
        rtc_alarm = 1'b0;
        wait_core();
        dpd_req = 1'b1;
        tick(1);
        dpd_req = 1'b0;
        pwr_on = 1'b0;
        por_detect = 1'b1;
        tick(10);
        chk(chip_reset_n, 0, "power removed");
        chk(core_reset_n, 0, "core alive unpowered");
        pwr_on = 1'b1;
        por_detect = 1'b0;
        wait_core();
        chk(reset_cause, 3, "power return cause");
        chk(clk_src_irc, 1, "clock source after power");
        $display("test power_down done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ten thousand cycles cover every start-up with the shortened counts
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
    initial begin
        tick(3);
        rst_n = 1'b1;
        t_power_up();
        t_sources();
        t_brownout();
        t_power_down();
        finish_test();
    end
endmodule
